// ==== rtl/mcs_pkg.sv ====
// shared constants of the modem function configuration header
package mcs_pkg;

  // ----------------------------------------------------------------
  // configuration byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_COMMAND = 8'h04;
  localparam logic [7:0] OFF_BASE_CLASS = 8'h0B;
  localparam logic [7:0] OFF_HEADER = 8'h0E;
  localparam logic [7:0] OFF_MIXER_BASE = 8'h10;
  localparam logic [7:0] OFF_BUSMASTER_BASE = 8'h14;
  localparam logic [7:0] OFF_SUBSYS_VENDOR = 8'h2C;
  localparam logic [7:0] OFF_SUBSYS = 8'h2E;
  localparam logic [7:0] OFF_CAPABILITY_LIST_POINTER = 8'h34;
  localparam logic [7:0] OFF_IRQ_LINE = 8'h3C;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h54;

  // ----------------------------------------------------------------
  // fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_CLASS_VAL = 8'h07;
  localparam logic [7:0] HEADER_VAL = 8'h00;
  localparam logic [7:0] CAPABILITY_LIST_POINTER_VAL = 8'h50;
  localparam logic [31:0] WINDOW_BASE_RST = 32'h00000001;
  localparam logic [15:0] SUBSYS_RST = 16'h0000;
  localparam logic [7:0] IRQ_LINE_RST = 8'h00;
  localparam logic IO_ENABLE_RST = 1'b0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IO_ENABLE_BIT = 0;
  localparam int RESOURCE_KIND_BIT = 0;
  localparam int BASE_MSB = 15;
  localparam int MIXER_BASE_LSB = 8;
  localparam int BUSMASTER_BASE_LSB = 7;
  localparam int CODEC_SELECT_BIT = 7;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  localparam logic [1:0] PSTATE_D0 = 2'b00;
  localparam logic [1:0] PSTATE_D3HOT = 2'b11;
  localparam logic [1:0] PSTATE_RST = 2'b00;

endpackage : mcs_pkg

// ==== rtl/mcs_io_window.sv ====
// address decode of one power-of-two i/o window
`timescale 1ns/1ps

module mcs_io_window #(
  parameter int LSB = 8
) (
  input wire logic [31:0] io_addr,
  input wire logic [mcs_pkg::BASE_MSB-LSB:0] base,
  output logic hit
);

  // addresses with any of bits 31:16 set never decode, only the low 64K does
  assign hit = (io_addr[31:16] == 16'h0000) && (io_addr[mcs_pkg::BASE_MSB:LSB] == base);

endmodule : mcs_io_window

// ==== rtl/mcs_write_once.sv ====
// 16-bit register that keeps only its first write
`timescale 1ns/1ps

module mcs_write_once (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  output logic [15:0] value,
  output logic locked
);

  logic [15:0] next_value;
  logic next_locked;

  // ----------------------------------------------------------------
  // capture and lock
  // ----------------------------------------------------------------
  always_comb begin
    next_value = value;
    next_locked = locked;
    if (wr_en && !locked && (wr_be != 2'b00)) begin
      if (wr_be[0]) begin
        next_value[7:0] = wr_data[7:0];
      end
      if (wr_be[1]) begin
        next_value[15:8] = wr_data[15:8];
      end
      next_locked = 1'b1;
    end
  end

  // only the full reset clears it, never a power state change
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      value <= mcs_pkg::SUBSYS_RST;
      locked <= 1'b0;
    end else begin
      value <= next_value;
      locked <= next_locked;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_locked_holds;
    @(posedge ref_clk) disable iff (!rst_n)
    (locked && wr_en) |=> (value == $past(value)) && locked;
  endproperty
  a_locked_holds: assert property (p_locked_holds) else $error("write-once value changed");

  property p_first_write_locks;
    @(posedge ref_clk) disable iff (!rst_n)
    (!locked && wr_en && (wr_be == 2'b11)) |=> locked && (value == $past(wr_data));
  endproperty
  a_first_write_locks: assert property (p_first_write_locks) else $error("first write lost");

endmodule : mcs_write_once

// ==== rtl/mcs_config_space.sv ====
// configuration header and i/o window routing of the modem function
// How it works
// - base class reads fixed 07h, writes ignored
// - mixer base bits 15:8 writable, 256-byte window
// - both window bases read zero in 31:16
// - bit 0 reads one, other low bits zero
// - mixer window accesses go to codec link
// - lower half primary codec, upper half secondary
// - bus-master base bits 15:7 writable, 128 bytes
// - bus-master window served locally unless the mixer window also hits
// - subsystem ids reset zero, first write sticks
// - subsystem ids survive low-power to on return
// - capability pointer reads constant 50h
// - interrupt line byte is scratch, reset zero
// - windows claimed only while i/o enable set
// - low-power state blocks i/o and interrupts
`timescale 1ns/1ps

module mcs_config_space (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic io_req,
  input wire logic io_we,
  input wire logic [31:0] io_addr,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic io_claim,
  output logic codec_req,
  output logic codec_secondary,
  output logic [6:0] codec_offset,
  output logic codec_we,
  output logic [3:0] codec_be,
  output logic [31:0] codec_wdata,
  output logic local_req,
  output logic [6:0] local_offset,
  output logic local_we,
  output logic [3:0] local_be,
  output logic [31:0] local_wdata,
  input wire logic fn_irq,
  output logic irq_out
);

  localparam int MIX_W = mcs_pkg::BASE_MSB - mcs_pkg::MIXER_BASE_LSB + 1;
  localparam int BM_W = mcs_pkg::BASE_MSB - mcs_pkg::BUSMASTER_BASE_LSB + 1;

  // ----------------------------------------------------------------
  // stored state
  // ----------------------------------------------------------------
  logic io_window_enable;
  logic [MIX_W-1:0] mixer_base;
  logic [BM_W-1:0] busmaster_base;
  logic [7:0] irq_routing_value;
  logic [1:0] power_state;
  logic [5:0] cfg_idx_q;
  logic cfg_rd_q;
  logic next_io_window_enable;
  logic [MIX_W-1:0] next_mixer_base;
  logic [BM_W-1:0] next_busmaster_base;
  logic [7:0] next_irq_routing_value;
  logic [1:0] next_power_state;
  logic next_cfg_ack;
  logic [31:0] next_cfg_rdata;

  logic [15:0] subsystem_vendor_ident;
  logic [15:0] subsystem_ident;
  logic cfg_wr;
  logic wr_subsystem_vendor_ident;
  logic wr_sid;
  logic [5:0] cfg_idx;
  logic [31:0] mixer_io_window_base;
  logic [31:0] busmaster_io_window_base;
  logic wake_reset;

  assign cfg_wr = cfg_req && cfg_we;
  assign cfg_idx = cfg_addr[7:2];
  assign wr_subsystem_vendor_ident = cfg_wr && (cfg_idx == mcs_pkg::OFF_SUBSYS_VENDOR[7:2]);
  assign wr_sid = cfg_wr && (cfg_idx == mcs_pkg::OFF_SUBSYS[7:2]);

  // ----------------------------------------------------------------
  // window base read images
  // ----------------------------------------------------------------
  always_comb begin
    mixer_io_window_base = 32'h00000000;
    mixer_io_window_base[mcs_pkg::BASE_MSB:mcs_pkg::MIXER_BASE_LSB] = mixer_base;
    mixer_io_window_base[mcs_pkg::RESOURCE_KIND_BIT] = 1'b1;
    busmaster_io_window_base = 32'h00000000;
    busmaster_io_window_base[mcs_pkg::BASE_MSB:mcs_pkg::BUSMASTER_BASE_LSB] = busmaster_base;
    busmaster_io_window_base[mcs_pkg::RESOURCE_KIND_BIT] = 1'b1;
  end

  // ----------------------------------------------------------------
  // write-once subsystem identifiers
  // ----------------------------------------------------------------
  mcs_write_once u_subsystem_vendor_ident (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_subsystem_vendor_ident),
    .wr_be(cfg_be[1:0]),
    .wr_data(cfg_wdata[15:0]),
    .value(subsystem_vendor_ident),
    .locked()
  );

  mcs_write_once u_sid (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_en(wr_sid),
    .wr_be(cfg_be[3:2]),
    .wr_data(cfg_wdata[31:16]),
    .value(subsystem_ident),
    .locked()
  );

  // ----------------------------------------------------------------
  // configuration writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    next_io_window_enable = io_window_enable;
    next_mixer_base = mixer_base;
    next_busmaster_base = busmaster_base;
    next_irq_routing_value = irq_routing_value;
    next_power_state = power_state;
    next_cfg_ack = cfg_req;
    next_cfg_rdata = 32'h00000000;
    wake_reset = 1'b0;
    // only writable fields are touched, anything else drops silently
    if (cfg_wr) begin
      if ((cfg_idx == mcs_pkg::OFF_COMMAND[7:2]) && cfg_be[0]) begin
        next_io_window_enable = cfg_wdata[mcs_pkg::IO_ENABLE_BIT];
      end
      if ((cfg_idx == mcs_pkg::OFF_MIXER_BASE[7:2]) && cfg_be[1]) begin
        next_mixer_base = cfg_wdata[mcs_pkg::BASE_MSB:mcs_pkg::MIXER_BASE_LSB];
      end
      if (cfg_idx == mcs_pkg::OFF_BUSMASTER_BASE[7:2]) begin
        if (cfg_be[1]) begin
          next_busmaster_base[BM_W-1:1] = cfg_wdata[15:8];
        end
        if (cfg_be[0]) begin
          next_busmaster_base[0] = cfg_wdata[mcs_pkg::BUSMASTER_BASE_LSB];
        end
      end
      if ((cfg_idx == mcs_pkg::OFF_IRQ_LINE[7:2]) && cfg_be[0]) begin
        next_irq_routing_value = cfg_wdata[7:0];
      end
      if ((cfg_idx == mcs_pkg::OFF_POWER_CTRL[7:2]) && cfg_be[0]) begin
        // unsupported states are discarded
        if ((cfg_wdata[1:0] == mcs_pkg::PSTATE_D0) || (cfg_wdata[1:0] == mcs_pkg::PSTATE_D3HOT)) begin
          next_power_state = cfg_wdata[1:0];
        end
      end
    end
    // return to on resets the function, subsystem ids excepted
    if ((power_state == mcs_pkg::PSTATE_D3HOT) && (next_power_state == mcs_pkg::PSTATE_D0)) begin
      wake_reset = 1'b1;
      next_io_window_enable = mcs_pkg::IO_ENABLE_RST;
      next_mixer_base = mcs_pkg::WINDOW_BASE_RST[mcs_pkg::BASE_MSB:mcs_pkg::MIXER_BASE_LSB];
      next_busmaster_base = mcs_pkg::WINDOW_BASE_RST[mcs_pkg::BASE_MSB:mcs_pkg::BUSMASTER_BASE_LSB];
      next_irq_routing_value = mcs_pkg::IRQ_LINE_RST;
    end
    if (cfg_req && !cfg_we) begin
      case (cfg_idx)
        mcs_pkg::OFF_COMMAND[7:2]: begin
          next_cfg_rdata[mcs_pkg::IO_ENABLE_BIT] = io_window_enable;
        end
        mcs_pkg::OFF_BASE_CLASS[7:2]: begin
          next_cfg_rdata[31:24] = mcs_pkg::BASE_CLASS_VAL;
        end
        mcs_pkg::OFF_HEADER[7:2]: begin
          next_cfg_rdata[23:16] = mcs_pkg::HEADER_VAL;
        end
        mcs_pkg::OFF_MIXER_BASE[7:2]: begin
          next_cfg_rdata = mixer_io_window_base;
        end
        mcs_pkg::OFF_BUSMASTER_BASE[7:2]: begin
          next_cfg_rdata = busmaster_io_window_base;
        end
        mcs_pkg::OFF_SUBSYS_VENDOR[7:2]: begin
          next_cfg_rdata = {subsystem_ident, subsystem_vendor_ident};
        end
        mcs_pkg::OFF_CAPABILITY_LIST_POINTER[7:2]: begin
          next_cfg_rdata[7:0] = mcs_pkg::CAPABILITY_LIST_POINTER_VAL;
        end
        mcs_pkg::OFF_IRQ_LINE[7:2]: begin
          next_cfg_rdata[7:0] = irq_routing_value;
        end
        mcs_pkg::OFF_POWER_CTRL[7:2]: begin
          next_cfg_rdata[1:0] = power_state;
        end
        default: begin
          next_cfg_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      io_window_enable <= mcs_pkg::IO_ENABLE_RST;
      mixer_base <= mcs_pkg::WINDOW_BASE_RST[mcs_pkg::BASE_MSB:mcs_pkg::MIXER_BASE_LSB];
      busmaster_base <= mcs_pkg::WINDOW_BASE_RST[mcs_pkg::BASE_MSB:mcs_pkg::BUSMASTER_BASE_LSB];
      irq_routing_value <= mcs_pkg::IRQ_LINE_RST;
      power_state <= mcs_pkg::PSTATE_RST;
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h00000000;
      cfg_idx_q <= 6'h00;
      cfg_rd_q <= 1'b0;
    end else begin
      io_window_enable <= next_io_window_enable;
      mixer_base <= next_mixer_base;
      busmaster_base <= next_busmaster_base;
      irq_routing_value <= next_irq_routing_value;
      power_state <= next_power_state;
      cfg_ack <= next_cfg_ack;
      cfg_rdata <= next_cfg_rdata;
      cfg_idx_q <= cfg_idx;
      cfg_rd_q <= cfg_req && !cfg_we;
    end
  end

  // ----------------------------------------------------------------
  // i/o window decode and routing
  // ----------------------------------------------------------------
  logic mix_hit;
  logic bm_hit;
  logic io_open;
  logic next_io_claim;
  logic next_codec_req;
  logic next_local_req;
  logic next_irq_out;

  mcs_io_window #(.LSB(mcs_pkg::MIXER_BASE_LSB)) u_mix_win (
    .io_addr(io_addr),
    .base(mixer_base),
    .hit(mix_hit)
  );

  mcs_io_window #(.LSB(mcs_pkg::BUSMASTER_BASE_LSB)) u_bm_win (
    .io_addr(io_addr),
    .base(busmaster_base),
    .hit(bm_hit)
  );

  // no claim while disabled or asleep
  assign io_open = io_req && io_window_enable && (power_state == mcs_pkg::PSTATE_D0);

  always_comb begin
    next_codec_req = io_open && mix_hit;
    next_local_req = io_open && bm_hit && !mix_hit;
    next_io_claim = next_codec_req || next_local_req;
    next_irq_out = fn_irq && (power_state == mcs_pkg::PSTATE_D0);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      io_claim <= 1'b0;
      codec_req <= 1'b0;
      codec_secondary <= 1'b0;
      codec_offset <= 7'h00;
      codec_we <= 1'b0;
      codec_be <= 4'h0;
      codec_wdata <= 32'h00000000;
      local_req <= 1'b0;
      local_offset <= 7'h00;
      local_we <= 1'b0;
      local_be <= 4'h0;
      local_wdata <= 32'h00000000;
      irq_out <= 1'b0;
    end else begin
      io_claim <= next_io_claim;
      codec_req <= next_codec_req;
      codec_secondary <= io_addr[mcs_pkg::CODEC_SELECT_BIT];
      codec_offset <= io_addr[6:0];
      codec_we <= io_we;
      codec_be <= io_be;
      codec_wdata <= io_wdata;
      local_req <= next_local_req;
      local_offset <= io_addr[6:0];
      local_we <= io_we;
      local_be <= io_be;
      local_wdata <= io_wdata;
      irq_out <= next_irq_out;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_mixer_access;
    io_req && io_window_enable && (power_state == mcs_pkg::PSTATE_D0) && mix_hit;
  endsequence

  sequence s_bm_access;
    io_req && io_window_enable && (power_state == mcs_pkg::PSTATE_D0) && bm_hit && !mix_hit;
  endsequence

  property p_base_class;
    (cfg_ack && cfg_rd_q && (cfg_idx_q == mcs_pkg::OFF_BASE_CLASS[7:2])) |-> (cfg_rdata[31:24] == 8'h07);
  endproperty
  a_base_class: assert property (p_base_class) else $error("base class wrong");

  property p_mixer_base_write;
    (cfg_wr && (cfg_idx == mcs_pkg::OFF_MIXER_BASE[7:2]) && (cfg_be == 4'hF)
      && (power_state == mcs_pkg::PSTATE_D0)) |=> (mixer_base == $past(cfg_wdata[15:8]));
  endproperty
  a_mixer_base_write: assert property (p_mixer_base_write) else $error("mixer base not stored");

  property p_upper_zero;
    (cfg_ack && cfg_rd_q && ((cfg_idx_q == mcs_pkg::OFF_MIXER_BASE[7:2])
      || (cfg_idx_q == mcs_pkg::OFF_BUSMASTER_BASE[7:2]))) |-> (cfg_rdata[31:16] == 16'h0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("window base upper bits set");

  property p_io_kind;
    (cfg_ack && cfg_rd_q && (cfg_idx_q == mcs_pkg::OFF_BUSMASTER_BASE[7:2])) |-> (cfg_rdata[6:0] == 7'h01);
  endproperty
  a_io_kind: assert property (p_io_kind) else $error("window base low bits wrong");

  property p_mixer_forward;
    s_mixer_access |=> codec_req && io_claim && !local_req;
  endproperty
  a_mixer_forward: assert property (p_mixer_forward) else $error("mixer access not forwarded");

  property p_codec_select;
    codec_req |-> (codec_secondary == $past(io_addr[7]));
  endproperty
  a_codec_select: assert property (p_codec_select) else $error("wrong codec selected");

  property p_bm_local;
    s_bm_access |=> local_req && !codec_req;
  endproperty
  a_bm_local: assert property (p_bm_local) else $error("bus-master access leaked to link");

  property p_capability_list_pointer;
    (cfg_ack && cfg_rd_q && (cfg_idx_q == mcs_pkg::OFF_CAPABILITY_LIST_POINTER[7:2])) |-> (cfg_rdata[7:0] == 8'h50);
  endproperty
  a_capability_list_pointer: assert property (p_capability_list_pointer) else $error("capability pointer wrong");

  property p_disabled_silent;
    (io_req && !io_window_enable) |=> !io_claim;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("claim while disabled");

  property p_sleep_blocks;
    (power_state == mcs_pkg::PSTATE_D3HOT) |=> !irq_out && !io_claim;
  endproperty
  a_sleep_blocks: assert property (p_sleep_blocks) else $error("activity in low-power state");

  property p_ids_survive_wake;
    wake_reset |=> $stable(subsystem_ident) && $stable(subsystem_vendor_ident);
  endproperty
  a_ids_survive_wake: assert property (p_ids_survive_wake) else $error("ids lost on wake");

endmodule : mcs_config_space

// ==== testbench/mcs_host_model.sv ====
// host bridge model issuing configuration and i/o cycles
`timescale 1ns/1ps

module mcs_host_model (
  input wire logic ref_clk,
  output logic cfg_req,
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic io_req,
  output logic io_we,
  output logic [31:0] io_addr,
  output logic [3:0] io_be,
  output logic [31:0] io_wdata,
  input wire logic io_claim,
  input wire logic codec_req,
  input wire logic codec_secondary,
  input wire logic [6:0] codec_offset,
  input wire logic local_req,
  input wire logic [6:0] local_offset,
  input wire logic codec_we,
  input wire logic [3:0] codec_be,
  input wire logic [31:0] codec_wdata,
  input wire logic local_we,
  input wire logic [3:0] local_be,
  input wire logic [31:0] local_wdata
);
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
    io_req = 1'b0;
    io_we = 1'b0;
    io_addr = 32'h00000000;
    io_be = 4'h0;
    io_wdata = 32'h00000000;
  end

  // one config access; answer taken one edge after the request
  task automatic cfg(input logic we, input logic [7:0] addr, input logic [3:0] be,
                     input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(posedge ref_clk);
    #1;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = wd;
    @(posedge ref_clk);
    #1;
    cfg_req = 1'b0;
    ack = cfg_ack;
    rd = cfg_rdata;
    @(posedge ref_clk);
    #1;
    // released address, enables and data show the inverse; cfg_we keeps its value
    cfg_addr = ~addr;
    cfg_be = ~be;
    cfg_wdata = ~wd;
  endtask : cfg

  // one i/o cycle; offsets and select packed only where their pulse is up
  task automatic io_acc(input logic [31:0] addr, input logic we, input logic [31:0] wd,
                        output logic [31:0] res, output logic [36:0] cw);
    @(posedge ref_clk);
    #1;
    io_req = 1'b1;
    io_we = we;
    io_addr = addr;
    io_be = 4'hF;
    io_wdata = wd;
    @(posedge ref_clk);
    #1;
    io_req = 1'b0;
    res = {9'h000, codec_req ? codec_offset : 7'h00, 1'b0, local_req ? local_offset : 7'h00,
           4'h0, io_claim, codec_req, local_req, codec_req & codec_secondary};
    // forwarded copies of the side whose pulse is up
    cw = codec_req ? {codec_we, codec_be, codec_wdata} : {local_we, local_be, local_wdata};
    @(posedge ref_clk);
    #1;
    io_addr = ~addr;
    io_we = ~we;
    io_be = 4'h0;
    io_wdata = ~wd;
  endtask : io_acc
endmodule : mcs_host_model

// ==== testbench/tb.sv ====
// self-checking bench of the modem function configuration header
`timescale 1ns/1ps

module tb;
  logic ref_clk, rst_n, fn_irq, irq_out;
  logic cfg_req, cfg_we, cfg_ack, io_req, io_we, io_claim;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, io_be;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr, io_wdata;
  logic codec_req, codec_secondary, local_req;
  logic [6:0] codec_offset, local_offset;
  logic codec_we, local_we;
  logic [3:0] codec_be, local_be;
  logic [31:0] codec_wdata, local_wdata;
  int fails = 0;
  int n_checks = 0;

  mcs_config_space uut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .io_req(io_req), .io_we(io_we), .io_addr(io_addr), .io_be(io_be),
    .io_wdata(io_wdata), .io_claim(io_claim), .codec_req(codec_req),
    .codec_secondary(codec_secondary), .codec_offset(codec_offset), .codec_we(codec_we),
    .codec_be(codec_be), .codec_wdata(codec_wdata), .local_req(local_req),
    .local_offset(local_offset), .local_we(local_we), .local_be(local_be),
    .local_wdata(local_wdata), .fn_irq(fn_irq), .irq_out(irq_out));

  mcs_host_model host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .io_req(io_req), .io_we(io_we), .io_addr(io_addr), .io_be(io_be),
    .io_wdata(io_wdata), .io_claim(io_claim), .codec_req(codec_req),
    .codec_secondary(codec_secondary), .codec_offset(codec_offset), .local_req(local_req),
    .local_offset(local_offset), .codec_we(codec_we), .codec_be(codec_be),
    .codec_wdata(codec_wdata), .local_we(local_we), .local_be(local_be),
    .local_wdata(local_wdata));

  // ----------------------------------------------------------------
  // shared checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic ack;
    logic [31:0] r;
    host.cfg(1'b1, a, be, d, ack, r);
    chk(32'h00000001, {31'h0, ack});
    chk(32'h00000000, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic ack;
    logic [31:0] r;
    host.cfg(1'b0, a, 4'hF, 32'h00000000, ack, r);
    chk(32'h00000001, {31'h0, ack});
    chk(exp, r & m);
  endtask : rd

  task automatic io(input logic [31:0] a, input logic cl, input logic c, input logic l,
                    input logic sec, input logic [6:0] off);
    logic [31:0] r;
    logic [36:0] cw;
    host.io_acc(a, 1'b0, 32'h00000000, r, cw);
    chk({9'h000, c ? off : 7'h00, 1'b0, l ? off : 7'h00, 4'h0, cl, c, l, sec}, r);
    if (cl) begin
      chk(32'h0000000F, {27'h0, cw[36:32]});
    end
  endtask : io

  task automatic io_wr(input logic [31:0] a, input logic [31:0] d, input logic c);
    logic [31:0] r;
    logic [36:0] cw;
    host.io_acc(a, 1'b1, d, r, cw);
    chk({29'h0, 1'b1, c, !c}, {29'h0, r[3:1]});
    chk(32'h0000001F, {27'h0, cw[36:32]});
    chk(d, cw[31:0]);
  endtask : io_wr

  task automatic irq_chk(input logic lvl, input logic exp);
    @(posedge ref_clk);
    #1;
    fn_irq = lvl;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({31'h0, exp}, {31'h0, irq_out});
  endtask : irq_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(8'h08, 32'h07000000, 32'hFFFFFFFF);
    rd(8'h0C, 32'h00000000, 32'h00FF0000);
    rd(8'h10, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h2C, 32'h00000000, 32'hFFFFFFFF);
    rd(8'h34, 32'h00000050, 32'h000000FF);
    rd(8'h3C, 32'h00000000, 32'h000000FF);
    rd(8'h04, 32'h00000000, 32'h00000001);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_fixed;
    wr(8'h08, 4'hF, 32'hFFFFFFFF);
    wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    wr(8'h34, 4'hF, 32'hFFFFFFFF);
    rd(8'h08, 32'h07000000, 32'hFFFFFFFF);
    rd(8'h0C, 32'h00000000, 32'h00FF0000);
    rd(8'h34, 32'h00000050, 32'h000000FF);
    wr(8'h10, 4'hF, 32'hFFFFFFFF);
    rd(8'h10, 32'h0000FF01, 32'hFFFFFFFF);
    wr(8'h14, 4'hF, 32'hFFFFFFFF);
    rd(8'h14, 32'h0000FF81, 32'hFFFFFFFF);
    $display("test fixed and base fields done");
  endtask : t_fixed

  task automatic t_ids;
    wr(8'h2C, 4'h3, 32'hFFFF1234);
    rd(8'h2C, 32'h00001234, 32'hFFFFFFFF);
    wr(8'h2C, 4'hF, 32'hABCD5678);
    rd(8'h2C, 32'hABCD1234, 32'hFFFFFFFF);
    wr(8'h3C, 4'h1, 32'h000000A5);
    rd(8'h3C, 32'h000000A5, 32'h000000FF);
    $display("test write-once ids done");
  endtask : t_ids

  task automatic t_io;
    wr(8'h10, 4'hF, 32'h00001200);
    wr(8'h14, 4'hF, 32'h00003480);
    io(32'h00001205, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    wr(8'h04, 4'h1, 32'h00000001);
    io(32'h00001205, 1'b1, 1'b1, 1'b0, 1'b0, 7'h05);
    io(32'h00001285, 1'b1, 1'b1, 1'b0, 1'b1, 7'h05);
    io(32'h000012FE, 1'b1, 1'b1, 1'b0, 1'b1, 7'h7E);
    io(32'h000034C3, 1'b1, 1'b0, 1'b1, 1'b0, 7'h43);
    io(32'h00003480, 1'b1, 1'b0, 1'b1, 1'b0, 7'h00);
    io_wr(32'h00001210, 32'hA5A55A5A, 1'b1);
    io_wr(32'h000034A0, 32'h0F0F0F0F, 1'b0);
    io(32'h0000347F, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    io(32'h00001300, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    io(32'h10001205, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    $display("test io windows done");
  endtask : t_io

  task automatic t_power;
    irq_chk(1'b1, 1'b1);
    wr(8'h54, 4'h1, 32'h00000003);
    irq_chk(1'b1, 1'b0);
    io(32'h00001205, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
    rd(8'h3C, 32'h000000A5, 32'h000000FF);
    wr(8'h54, 4'h1, 32'h00000001);
    rd(8'h54, 32'h00000003, 32'h00000003);
    wr(8'h54, 4'h1, 32'h00000000);
    irq_chk(1'b0, 1'b0);
    rd(8'h2C, 32'hABCD1234, 32'hFFFFFFFF);
    wr(8'h2C, 4'hF, 32'h00000000);
    rd(8'h2C, 32'hABCD1234, 32'hFFFFFFFF);
    rd(8'h04, 32'h00000000, 32'h00000001);
    $display("test power states done");
  endtask : t_power

  // ----------------------------------------------------------------
  // clock, reset, sequence and verdict
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // watchdog against a hang
  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    fn_irq = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_fixed();
    t_ids();
    t_io();
    t_power();
    conclude();
  end
endmodule : tb
